// ==== core/psl_phase_counter.sv ====
`timescale 1ns/1ps
// counts output-word-rate samples from a start until the chosen zero crossing
module psl_phase_counter
  import psl_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control from the register file
  input wire logic start,
  input wire logic dir,
  // sample and zero-crossing events, same clock
  input wire logic owr_tick,
  input wire logic zc_rise,
  input wire logic zc_fall,
  // result
  output logic [CW-1:0] count,
  output logic done,
  output logic busy
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  psl_ph_state_t state_r; // idle or counting
  psl_ph_state_t state_nxt;
  logic [CW-1:0] count_r; // samples since start
  logic [CW-1:0] count_nxt;
  logic done_r; // count holds a valid result
  logic done_nxt;
  logic dir_r; // edge latched at start

  // selected edge ends the count; saturate so the field never wraps
  wire stop_edge = (dir_r == PH_DIR_RISE) ? zc_rise : zc_fall;
  wire cnt_full = &count_r;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    done_nxt = done_r;
    unique case (state_r)
      PH_IDLE:
      begin
        // nothing counts until software starts a run
      end
      PH_COUNT:
      begin
        if (stop_edge)
        begin
          state_nxt = PH_IDLE;
          done_nxt = 1'b1;
        end
        else if (owr_tick && !cnt_full)
        begin
          count_nxt = count_r + 1'b1;
        end
      end
    endcase
    // a new start restarts a run in progress as well
    if (start)
    begin
      state_nxt = PH_COUNT;
      count_nxt = '0;
      done_nxt = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= PH_IDLE;
      count_r <= '0;
      done_r <= 1'b0;
      dir_r <= PH_DIR_RISE;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      done_r <= done_nxt;
      if (start)
      begin
        dir_r <= dir;
      end
    end
  end

  assign count = count_r;
  assign done = done_r;
  assign busy = (state_r == PH_COUNT);

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  start_clears_a: assert property (@(posedge clk) disable iff (reset)
    start |=> (!done_r && count_r == '0 && state_r == PH_COUNT))
    else $error("start did not clear flag and count");

  done_idle_a: assert property (@(posedge clk) disable iff (reset)
    done_r |-> state_r == PH_IDLE)
    else $error("valid flag set while still counting");

  edge_stops_a: assert property (@(posedge clk) disable iff (reset)
    (state_r == PH_COUNT && !start && stop_edge) |=> (done_r && state_r == PH_IDLE))
    else $error("selected edge did not end the count");

  tick_counts_a: assert property (@(posedge clk) disable iff (reset)
    (state_r == PH_COUNT && !start && !stop_edge && owr_tick && !cnt_full)
      |=> count_r == $past(count_r) + 1'b1)
    else $error("sample tick not counted");

endmodule

// ==== core/psl_pkg.sv ====
// Contract
// - three 4-bit generator source fields, rest reserved
// - selector codes 0 to 8 used, 9-15 unused
// - engine key 0x16 locks, 0x09 unlocks
// - serial key 0x16 blocks writes, 0x09 restores
// - lock and status registers stay writable
// - valid flag only with valid count, else 0
// - count samples until selected zero-crossing edge
// - checksum readable, read-only, zero after reset
package psl_pkg;

  // -----------------------------------------------------------------
  // widths
  // -----------------------------------------------------------------
  localparam int DATA_W = 24; // register word width
  localparam int PAGE_W = 6; // serial page number width
  localparam int ADDR_W = 6; // serial address width
  localparam int SEL_W = 4; // one source selector field
  localparam int KEY_W = 5; // lock and start key fields
  localparam int CNT_W = 7; // phase sample count width

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [PAGE_W-1:0] PAGE_CFG = 6'h00; // configuration page
  localparam logic [PAGE_W-1:0] PAGE_CHK = 6'h10; // checksum page
  localparam logic [ADDR_W-1:0] ADDR_PULSE_SEL = 6'h09; // pulse_source_select
  localparam logic [ADDR_W-1:0] ADDR_LOCK = 6'h22; // write_lock_control
  localparam logic [ADDR_W-1:0] ADDR_CHK = 6'h01; // critical_checksum
  localparam logic [ADDR_W-1:0] ADDR_PHASE = 6'h38; // phase_sequence_detect
  localparam logic [ADDR_W-1:0] ADDR_STAT0 = 6'h17; // status 0, outside this block
  localparam logic [ADDR_W-1:0] ADDR_STAT1 = 6'h18; // status 1, outside this block
  localparam logic [ADDR_W-1:0] ADDR_STAT2 = 6'h19; // status 2, outside this block
  localparam logic [DATA_W-1:0] RST_WORD = 24'h000000; // reset value of every register word; the used flags reset to ones

  // -----------------------------------------------------------------
  // pulse_source_select fields and codes
  // -----------------------------------------------------------------
  localparam int SEL1_LSB = 0;
  localparam int SEL2_LSB = 4;
  localparam int SEL3_LSB = 8;
  localparam int SEL_USED_W = 12; // bits above read as zero
  localparam logic [SEL_W-1:0] SRC_AVG_ACTIVE_1 = 4'h0;
  localparam logic [SEL_W-1:0] SRC_AVG_ACTIVE_2 = 4'h1;
  localparam logic [SEL_W-1:0] SRC_ACTIVE_SUM = 4'h2;
  localparam logic [SEL_W-1:0] SRC_AVG_REACTIVE_1 = 4'h3;
  localparam logic [SEL_W-1:0] SRC_AVG_REACTIVE_2 = 4'h4;
  localparam logic [SEL_W-1:0] SRC_REACTIVE_SUM = 4'h5;
  localparam logic [SEL_W-1:0] SRC_APPARENT_1 = 4'h6;
  localparam logic [SEL_W-1:0] SRC_APPARENT_2 = 4'h7;
  localparam logic [SEL_W-1:0] SRC_APPARENT_SUM = 4'h8; // highest used code

  // -----------------------------------------------------------------
  // write_lock_control fields and keys
  // -----------------------------------------------------------------
  localparam int HOST_KEY_LSB = 0;
  localparam int ENG_KEY_LSB = 8;
  localparam logic [KEY_W-1:0] KEY_LOCK = 5'h16;
  localparam logic [KEY_W-1:0] KEY_UNLOCK = 5'h09;

  // -----------------------------------------------------------------
  // phase_sequence_detect fields
  // -----------------------------------------------------------------
  localparam int PH_CODE_LSB = 0;
  localparam int PH_DIR_BIT = 5;
  localparam int PH_CNT_LSB = 16;
  localparam int PH_DONE_BIT = 23;
  localparam logic [KEY_W-1:0] PH_START_CODE = 5'h16; // pattern 10110
  localparam logic PH_DIR_RISE = 1'b0; // stop on negative-to-positive

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    KEY_KEEP = 2'b00,
    KEY_DO_LOCK = 2'b01,
    KEY_DO_UNLOCK = 2'b10
  } psl_key_act_t;

  typedef enum logic
  {
    PH_IDLE = 1'b0,
    PH_COUNT = 1'b1
  } psl_ph_state_t;

endpackage

// ==== core/psl_regs.sv ====
`timescale 1ns/1ps
// pulse source select, write lock, phase sequence and checksum registers
module psl_regs
  import psl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // decoded serial register access
  input wire logic ser_wr_stb,
  input wire logic ser_rd_stb,
  input wire logic [PAGE_W-1:0] ser_page,
  input wire logic [ADDR_W-1:0] ser_addr,
  input wire logic [DATA_W-1:0] ser_wdata,
  // serial answers
  output logic [DATA_W-1:0] ser_rdata,
  output logic ser_rd_valid,
  output logic ser_rd_hit,
  output logic ser_wr_taken,
  output logic ser_wr_refused,
  output logic ext_wr_ok,
  // calculation engine side
  input wire logic eng_wr_req,
  output logic eng_wr_grant,
  output logic eng_locked,
  input wire logic chk_upd,
  input wire logic [DATA_W-1:0] chk_value,
  // energy pulse generator sources
  output logic [SEL_W-1:0] pulse_gen_source_field_1,
  output logic [SEL_W-1:0] pulse_gen_source_field_2,
  output logic [SEL_W-1:0] pulse_gen_source_field_3,
  output logic [2:0] pulse_gen_source_used,
  // phase sequence events, same clock
  input wire logic owr_tick,
  input wire logic zc_rise,
  input wire logic zc_fall,
  // lock state for the rest of the device
  output logic serial_locked
);

  // -----------------------------------------------------------------
  // key decode, used for both lock fields
  // -----------------------------------------------------------------
  function automatic psl_key_act_t key_act(input logic [KEY_W-1:0] key);
    psl_key_act_t act;
    act = KEY_KEEP;
    if (key == KEY_LOCK)
    begin
      act = KEY_DO_LOCK;
    end
    else if (key == KEY_UNLOCK)
    begin
      act = KEY_DO_UNLOCK;
    end
    return act;
  endfunction

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [SEL_USED_W-1:0] sel_r; // three selector fields
  logic [KEY_W-1:0] host_key_r; // last written serial key
  logic [KEY_W-1:0] eng_key_r; // last written engine key
  logic host_locked_r; // serial writes blocked
  logic eng_locked_r; // engine writes blocked
  logic ph_dir_r; // stop edge select
  logic [KEY_W-1:0] ph_code_r; // last written start code
  logic [DATA_W-1:0] chk_r; // checksum snapshot
  logic [DATA_W-1:0] rdata_r;
  logic rd_valid_r;
  logic rd_hit_r;
  logic wr_taken_r;
  logic wr_refused_r;
  logic ext_wr_ok_r;
  logic eng_grant_r;
  logic [2:0] used_r; // selector holds a used code
  logic [CNT_W-1:0] ph_count; // from the counter
  logic ph_done;
  logic ph_busy;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  wire pg_cfg = (ser_page == PAGE_CFG);
  wire hit_sel = pg_cfg && (ser_addr == ADDR_PULSE_SEL);
  wire hit_lock = pg_cfg && (ser_addr == ADDR_LOCK);
  wire hit_phase = pg_cfg && (ser_addr == ADDR_PHASE);
  wire hit_chk = (ser_page == PAGE_CHK) && (ser_addr == ADDR_CHK);
  wire hit_stat = pg_cfg && (ser_addr == ADDR_STAT0 || ser_addr == ADDR_STAT1
                             || ser_addr == ADDR_STAT2);
  wire hit_own = hit_sel || hit_lock || hit_phase || hit_chk;
  // lock and status stay open so a locked host can unlock and clear flags
  wire exempt = hit_lock || hit_stat;
  wire wr_ok = ser_wr_stb && (!host_locked_r || exempt);
  wire wr_block = ser_wr_stb && host_locked_r && !exempt;
  wire wr_sel = wr_ok && hit_sel;
  wire wr_lock = wr_ok && hit_lock;
  wire wr_phase = wr_ok && hit_phase;
  wire [KEY_W-1:0] w_host_key = ser_wdata[HOST_KEY_LSB +: KEY_W];
  wire [KEY_W-1:0] w_eng_key = ser_wdata[ENG_KEY_LSB +: KEY_W];
  wire [KEY_W-1:0] w_ph_code = ser_wdata[PH_CODE_LSB +: KEY_W];
  wire psl_key_act_t host_act = key_act(w_host_key);
  wire psl_key_act_t eng_act = key_act(w_eng_key);
  // detection runs only for the start pattern written by software
  wire ph_start = wr_phase && (w_ph_code == PH_START_CODE);

  // -----------------------------------------------------------------
  // read words
  // -----------------------------------------------------------------
  wire [DATA_W-1:0] sel_word = {{(DATA_W-SEL_USED_W){1'b0}}, sel_r};
  wire [DATA_W-1:0] lock_word = {{(DATA_W-ENG_KEY_LSB-KEY_W){1'b0}}, eng_key_r,
                                 {(ENG_KEY_LSB-KEY_W){1'b0}}, host_key_r};
  wire [DATA_W-1:0] ph_word = {ph_done, ph_count,
                               {(PH_CNT_LSB-PH_DIR_BIT-1){1'b0}}, ph_dir_r, ph_code_r};
  wire [DATA_W-1:0] rd_word = hit_sel ? sel_word :
                              hit_lock ? lock_word :
                              hit_phase ? ph_word :
                              hit_chk ? chk_r : RST_WORD;

  // -----------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sel_r <= RST_WORD[SEL_USED_W-1:0];
      host_key_r <= RST_WORD[KEY_W-1:0];
      eng_key_r <= RST_WORD[KEY_W-1:0];
      ph_dir_r <= PH_DIR_RISE;
      ph_code_r <= RST_WORD[KEY_W-1:0];
    end
    else
    begin
      if (wr_sel)
      begin
        sel_r <= ser_wdata[SEL_USED_W-1:0];
      end
      if (wr_lock)
      begin
        host_key_r <= w_host_key;
        eng_key_r <= w_eng_key;
      end
      if (wr_phase)
      begin
        ph_dir_r <= ser_wdata[PH_DIR_BIT];
        ph_code_r <= w_ph_code;
      end
    end
  end

  // -----------------------------------------------------------------
  // protection state, held apart from the key fields
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      host_locked_r <= 1'b0;
      eng_locked_r <= 1'b0;
    end
    else if (wr_lock)
    begin
      if (host_act == KEY_DO_LOCK)
      begin
        host_locked_r <= 1'b1;
      end
      else if (host_act == KEY_DO_UNLOCK)
      begin
        host_locked_r <= 1'b0;
      end
      if (eng_act == KEY_DO_LOCK)
      begin
        eng_locked_r <= 1'b1;
      end
      else if (eng_act == KEY_DO_UNLOCK)
      begin
        eng_locked_r <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // checksum snapshot; serial writes never reach it
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chk_r <= RST_WORD;
    end
    else if (chk_upd)
    begin
      chk_r <= chk_value;
    end
  end

  // -----------------------------------------------------------------
  // one-cycle answers to serial and engine requests
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_r <= RST_WORD;
      rd_valid_r <= 1'b0;
      rd_hit_r <= 1'b0;
      wr_taken_r <= 1'b0;
      wr_refused_r <= 1'b0;
      ext_wr_ok_r <= 1'b0;
      eng_grant_r <= 1'b0;
    end
    else
    begin
      rdata_r <= ser_rd_stb ? rd_word : RST_WORD;
      rd_valid_r <= ser_rd_stb;
      rd_hit_r <= ser_rd_stb && hit_own;
      wr_taken_r <= wr_ok && (hit_sel || hit_lock || hit_phase);
      wr_refused_r <= wr_block;
      // writes to registers kept elsewhere obey the serial lock, except the exempt status registers
      ext_wr_ok_r <= wr_ok && !hit_own;
      eng_grant_r <= eng_wr_req && !eng_locked_r;
    end
  end

  // -----------------------------------------------------------------
  // per-generator used-code flags; codes above the sum are unused
  // -----------------------------------------------------------------
  // selector as it stands after this cycle's write, so the flags track sel_r
  wire [SEL_USED_W-1:0] sel_nxt = wr_sel ? ser_wdata[SEL_USED_W-1:0] : sel_r;
  wire [2:0] used_nxt; // used flags for the next cycle

  // the word goes in as an argument so the assign wakes when it changes
  function automatic logic [SEL_W-1:0] sel_field(input logic [SEL_USED_W-1:0] v,
    input int idx);
    return v[idx*SEL_W +: SEL_W];
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_used
      assign used_nxt[g] = (sel_field(sel_nxt, g) <= SRC_APPARENT_SUM);
    end
  endgenerate

  // one process owns all three flags
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      used_r <= '1;
    end
    else
    begin
      used_r <= used_nxt;
    end
  end

  // -----------------------------------------------------------------
  // phase sequence counter
  // -----------------------------------------------------------------
  psl_phase_counter #(.CW(CNT_W)) u_phase
  (
    .clk(clk),
    .reset(reset),
    .start(ph_start),
    .dir(ser_wdata[PH_DIR_BIT]),
    .owr_tick(owr_tick),
    .zc_rise(zc_rise),
    .zc_fall(zc_fall),
    .count(ph_count),
    .done(ph_done),
    .busy(ph_busy)
  );

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign ser_rdata = rdata_r;
  assign ser_rd_valid = rd_valid_r;
  assign ser_rd_hit = rd_hit_r;
  assign ser_wr_taken = wr_taken_r;
  assign ser_wr_refused = wr_refused_r;
  assign ext_wr_ok = ext_wr_ok_r;
  assign eng_wr_grant = eng_grant_r;
  assign eng_locked = eng_locked_r;
  assign serial_locked = host_locked_r;
  assign pulse_gen_source_field_1 = sel_r[SEL1_LSB +: SEL_W];
  assign pulse_gen_source_field_2 = sel_r[SEL2_LSB +: SEL_W];
  assign pulse_gen_source_field_3 = sel_r[SEL3_LSB +: SEL_W];
  assign pulse_gen_source_used = used_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  locked_sel_a: assert property (@(posedge clk) disable iff (reset)
    (host_locked_r && ser_wr_stb && hit_sel) |=> (sel_r == $past(sel_r) && wr_refused_r))
    else $error("selector written while serial lock active");

  unlock_open_a: assert property (@(posedge clk) disable iff (reset)
    (host_locked_r && ser_wr_stb && hit_lock && w_host_key == KEY_UNLOCK) |=> !host_locked_r)
    else $error("lock register not writable while locked");

  host_key_a: assert property (@(posedge clk) disable iff (reset)
    (wr_lock && w_host_key == KEY_LOCK) |=> host_locked_r ##1 (ser_wr_stb && hit_sel
      && host_locked_r) |-> ##1 wr_refused_r)
    else $error("serial lock key did not block writes");

  eng_key_a: assert property (@(posedge clk) disable iff (reset)
    (wr_lock && w_eng_key == KEY_LOCK) ##[1:4] (eng_wr_req && eng_locked_r) |=> !eng_wr_grant)
    else $error("engine write granted after lock key");

  other_key_a: assert property (@(posedge clk) disable iff (reset)
    (wr_lock && host_act == KEY_KEEP && eng_act == KEY_KEEP)
      |=> $stable(host_locked_r) && $stable(eng_locked_r))
    else $error("non-key value changed protection state");

  chk_hold_a: assert property (@(posedge clk) disable iff (reset)
    (!chk_upd && ser_wr_stb && hit_chk) |=> $stable(chk_r))
    else $error("checksum changed by serial write");

  sel_reserved_a: assert property (@(posedge clk) disable iff (reset)
    (rd_valid_r && $past(hit_sel)) |-> rdata_r == {{(DATA_W-SEL_USED_W){1'b0}}, $past(sel_r)})
    else $error("reserved selector bits read nonzero");

  start_read_a: assert property (@(posedge clk) disable iff (reset)
    ph_start |=> (!ph_done && ph_count == '0))
    else $error("start did not clear phase result");

  unused_code_a: assert property (@(posedge clk) disable iff (reset)
    (sel_r[SEL1_LSB +: SEL_W] > SRC_APPARENT_SUM) |-> !used_r[0])
    else $error("unused code flagged as used");

  busy_valid_a: assert property (@(posedge clk) disable iff (reset)
    ph_busy |-> !ph_done)
    else $error("valid flag set while counter busy");

endmodule

// ==== dv/psl_regs_tb.sv ====
`timescale 1ns/1ps
module psl_regs_tb;
  import psl_pkg::*;
  // ----
  // stimulus and observed signals
  // ----
  logic clk;
  logic reset;
  logic ser_wr_stb;
  logic ser_rd_stb;
  logic [PAGE_W-1:0] ser_page;
  logic [ADDR_W-1:0] ser_addr;
  logic [DATA_W-1:0] ser_wdata;
  logic [DATA_W-1:0] ser_rdata;
  logic [DATA_W-1:0] chk_value;
  logic ser_rd_valid, ser_rd_hit, ser_wr_taken, ser_wr_refused, ext_wr_ok;
  logic eng_wr_req, eng_wr_grant, eng_locked, chk_upd, serial_locked;
  logic owr_tick, zc_rise, zc_fall;
  logic [SEL_W-1:0] src1, src2, src3;
  logic [2:0] src_used;
  int fail_count;
  int samples_checked;
  // one selector case: written word, read-back word, used flags
  typedef struct {logic [23:0] wd; logic [23:0] rb; logic [2:0] used;} psl_row_t;
  // reserved bits written high must read back low; 9..F are unused codes
  psl_row_t rows [6] = '{'{24'hFFF210, 24'h000210, 3'h7}, '{24'h000876, 24'h000876, 3'h7},
    '{24'h000543, 24'h000543, 3'h7}, '{24'h000009, 24'h000009, 3'h6},
    '{24'h000F00, 24'h000F00, 3'h3}, '{24'h0000A0, 24'h0000A0, 3'h5}};

  psl_regs DUT (.clk(clk), .reset(reset), .ser_wr_stb(ser_wr_stb), .ser_rd_stb(ser_rd_stb),
    .ser_page(ser_page), .ser_addr(ser_addr), .ser_wdata(ser_wdata), .ser_rdata(ser_rdata),
    .ser_rd_valid(ser_rd_valid), .ser_rd_hit(ser_rd_hit), .ser_wr_taken(ser_wr_taken),
    .ser_wr_refused(ser_wr_refused), .ext_wr_ok(ext_wr_ok), .eng_wr_req(eng_wr_req),
    .eng_wr_grant(eng_wr_grant), .eng_locked(eng_locked), .chk_upd(chk_upd),
    .chk_value(chk_value), .pulse_gen_source_field_1(src1), .pulse_gen_source_field_2(src2),
    .pulse_gen_source_field_3(src3), .pulse_gen_source_used(src_used), .owr_tick(owr_tick),
    .zc_rise(zc_rise), .zc_fall(zc_fall), .serial_locked(serial_locked));

  // ----
  // shared tasks
  // ----
  // compare and count; unknowns never match
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // serial write, answer flags {taken, refused, ext_ok} one cycle later
  task automatic wr(input logic [5:0] p, input logic [5:0] a, input logic [23:0] d,
    input logic [2:0] ans);
    @(posedge clk);
    ser_wr_stb <= 1'b1;
    ser_page <= p;
    ser_addr <= a;
    ser_wdata <= d;
    @(posedge clk);
    ser_wr_stb <= 1'b0;
    #1;
    chk({21'h000000, ser_wr_taken, ser_wr_refused, ext_wr_ok}, {21'h000000, ans});
  endtask

  // serial read, data and hit looked at in the single answer cycle
  task automatic rd(input logic [5:0] p, input logic [5:0] a, input logic [23:0] exp,
    input logic hit);
    @(posedge clk);
    ser_rd_stb <= 1'b1;
    ser_page <= p;
    ser_addr <= a;
    @(posedge clk);
    ser_rd_stb <= 1'b0;
    #1;
    chk(ser_rdata, exp);
    chk({22'h000000, ser_rd_valid, ser_rd_hit}, {22'h000000, 1'b1, hit});
  endtask

  // one-cycle pulse on the sample and crossing inputs
  task automatic ev(input logic t, input logic r, input logic f);
    @(posedge clk);
    owr_tick <= t;
    zc_rise <= r;
    zc_fall <= f;
    @(posedge clk);
    {owr_tick, zc_rise, zc_fall} <= 3'h0;
  endtask

  // engine write request, grant expected or not
  task automatic eng(input logic g);
    @(posedge clk);
    eng_wr_req <= 1'b1;
    @(posedge clk);
    eng_wr_req <= 1'b0;
    #1;
    chk({23'h000000, eng_wr_grant}, {23'h000000, g});
  endtask

  // verdict and end of run
  task automatic close_out;
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----
  // clock and watchdog
  // ----
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // the sequence needs about 120 cycles; this is 4000 cycles, some thirty times that
  initial
  begin
    #200000;
    fail_count++;
    close_out();
  end

  // ----
  // main sequence
  // ----
  initial
  begin
    {reset, ser_wr_stb, ser_rd_stb, eng_wr_req, chk_upd} = 5'h10;
    {owr_tick, zc_rise, zc_fall} = 3'h0;
    ser_page = 6'h00;
    ser_addr = 6'h00;
    ser_wdata = 24'h000000;
    chk_value = 24'h000000;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    // reset state of outputs and all four words
    chk({7'h00, src_used, serial_locked, eng_locked, src3, src2, src1}, 24'h01C000);
    rd(PAGE_CFG, ADDR_PULSE_SEL, 24'h000000, 1'b1);
    rd(PAGE_CFG, ADDR_LOCK, 24'h000000, 1'b1);
    rd(PAGE_CFG, ADDR_PHASE, 24'h000000, 1'b1);
    rd(PAGE_CHK, ADDR_CHK, 24'h000000, 1'b1);
    rd(PAGE_CFG, 6'h3F, 24'h000000, 1'b0);
    // selector table
    foreach (rows[i])
    begin
      wr(PAGE_CFG, ADDR_PULSE_SEL, rows[i].wd, 3'h4);
      chk({12'h000, src3, src2, src1}, rows[i].rb);
      chk({21'h000000, src_used}, {21'h000000, rows[i].used});
      rd(PAGE_CFG, ADDR_PULSE_SEL, rows[i].rb, 1'b1);
    end
    // serial lock: refused, exempt, other key, unlock
    wr(PAGE_CFG, ADDR_LOCK, 24'h000016, 3'h4);
    chk({23'h000000, serial_locked}, 24'h000001);
    wr(PAGE_CFG, ADDR_PULSE_SEL, 24'h000123, 3'h2);
    wr(PAGE_CFG, ADDR_PHASE, 24'h000016, 3'h2);
    rd(PAGE_CFG, ADDR_PULSE_SEL, 24'h0000A0, 1'b1);
    wr(PAGE_CFG, ADDR_STAT0, 24'h000001, 3'h1);
    wr(PAGE_CFG, ADDR_STAT2, 24'h000001, 3'h1);
    wr(PAGE_CFG, ADDR_LOCK, 24'h000003, 3'h4);
    chk({23'h000000, serial_locked}, 24'h000001);
    wr(PAGE_CFG, ADDR_LOCK, 24'h000009, 3'h4);
    chk({23'h000000, serial_locked}, 24'h000000);
    wr(PAGE_CFG, ADDR_STAT1, 24'h000001, 3'h1);
    // engine lock
    eng(1'b1);
    wr(PAGE_CFG, ADDR_LOCK, 24'h001600, 3'h4);
    chk({23'h000000, eng_locked}, 24'h000001);
    eng(1'b0);
    wr(PAGE_CFG, ADDR_LOCK, 24'h001F00, 3'h4);
    eng(1'b0);
    wr(PAGE_CFG, ADDR_LOCK, 24'h000900, 3'h4);
    eng(1'b1);
    // checksum load, then a write that must be ignored
    @(posedge clk);
    chk_upd <= 1'b1;
    chk_value <= 24'hA5C3E1;
    @(posedge clk);
    chk_upd <= 1'b0;
    rd(PAGE_CHK, ADDR_CHK, 24'hA5C3E1, 1'b1);
    wr(PAGE_CHK, ADDR_CHK, 24'h000000, 3'h0);
    rd(PAGE_CHK, ADDR_CHK, 24'hA5C3E1, 1'b1);
    // phase detection, rising edge stop; the falling edge must not stop it
    wr(PAGE_CFG, ADDR_PHASE, 24'h000016, 3'h4);
    rd(PAGE_CFG, ADDR_PHASE, 24'h000016, 1'b1);
    repeat (3) ev(1'b1, 1'b0, 1'b0);
    ev(1'b0, 1'b0, 1'b1);
    rd(PAGE_CFG, ADDR_PHASE, 24'h030016, 1'b1);
    ev(1'b0, 1'b1, 1'b0);
    rd(PAGE_CFG, ADDR_PHASE, 24'h830016, 1'b1);
    // falling edge stop; a tick in the stop cycle is not counted
    wr(PAGE_CFG, ADDR_PHASE, 24'h000036, 3'h4);
    rd(PAGE_CFG, ADDR_PHASE, 24'h000036, 1'b1);
    repeat (2) ev(1'b1, 1'b0, 1'b0);
    ev(1'b0, 1'b1, 1'b0);
    ev(1'b1, 1'b0, 1'b1);
    rd(PAGE_CFG, ADDR_PHASE, 24'h820036, 1'b1);
    // another code only stores dir and code
    wr(PAGE_CFG, ADDR_PHASE, 24'h000001, 3'h4);
    rd(PAGE_CFG, ADDR_PHASE, 24'h820001, 1'b1);
    // second reset while the counter is idle and holds a result
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({7'h00, src_used, serial_locked, eng_locked, src3, src2, src1}, 24'h01C000);
    rd(PAGE_CFG, ADDR_PHASE, 24'h000000, 1'b1);
    rd(PAGE_CHK, ADDR_CHK, 24'h000000, 1'b1);
    rd(PAGE_CFG, ADDR_PULSE_SEL, 24'h000000, 1'b1);
    close_out();
  end
endmodule
